// *** sim/hdlc_datalink_buffer_count_bench.sv ***
// self-checking bench for the data-link buffer and count block
`timescale 1ns/1ns
`default_nettype none
module hdlc_datalink_buffer_count_bench;
  logic        clk, rst_n, psel, penable, pwrite, done, pat, mdone, mbuf;
  logic        busy, bbuf, mmode, infcs, irq, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  msize;
  int          err_count = 0, num_checks = 0, units, fcs_units, n, i;
  hdlc_datalink_buffer_count uut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .TX_UNIT_DONE_IN(done), .RX_PATTERN_IN(pat), .RX_MSG_DONE_IN(mdone),
    .RX_MSG_SIZE_IN(msize), .RX_MSG_BUF_IN(mbuf), .TX_BUSY_OUT(busy),
    .TX_BUSY_BUF_OUT(bbuf), .TX_MSG_MODE_OUT(mmode), .TX_IN_FCS_OUT(infcs), .IRQ_OUT(irq));
  hdlc_remote_term rt (.clk_in(clk), .busy_in(busy), .unit_done_out(done),
    .pattern_out(pat), .msg_done_out(mdone), .msg_size_out(msize), .msg_buf_out(mbuf));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (busy === 1'b1 && done === 1'b1) begin
      units++;
      fcs_units += infcs;
    end
  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", a > 12'h010, pslverr);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tx_run(bit msg, bit fcs, bit b, int c);
    apb(1, 12'h008, {fcs, msg});
    units = 0;
    fcs_units = 0;
    apb(1, 12'h000, {b, c[6:0]});
    @(negedge clk);
    chk("tx busy", 1, busy);
    chk("tx buf", b, bbuf);
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk("free buf", !b, rd[7]);
    for (i = 0; i < 500 && busy !== 1'b0; i++) @(posedge clk);
    chk("tx end", 0, busy);
    chk("units", c + ((msg && fcs) ? 2 : 0), units);
    chk("fcs units", (msg && fcs) ? 2 : 0, fcs_units);
    apb(0, 12'h000, 0);
    chk("sel count", {b, c[6:0]}, rd);
    apb(0, 12'h00C, 0);
    chk("tx eot", 1, rd[0]);
    chk("irq on", 1, irq);
    apb(1, 12'h00C, 1);
    chk("irq off", 0, irq);
    $display("tx test done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    finish_test;
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    n = $urandom(32'hC6C0);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk("tx reg", 0, rd);
    apb(0, 12'h004, 0);
    chk("rx reg", 0, rd);
    apb(0, 12'h014, 0);
    chk("unmapped", 0, rd);
    apb(1, 12'h010, 3);
    $display("reset test done");
    tx_run(0, 0, 1, 4 + $urandom_range(5));
    tx_run(1, 1, 0, 4 + $urandom_range(5));
    tx_run(1, 0, 1, 4 + $urandom_range(5));
    apb(1, 12'h008, 0);
    apb(1, 12'h000, 0);
    repeat (40) @(posedge clk);
    chk("endless", 1, busy);
    $display("endless test done");
    // reset ends the endless repeat here, as would a write of a nonzero count or of message mode
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset busy", 0, busy);
    apb(0, 12'h000, 0);
    chk("reset tx reg", 0, rd);
    apb(1, 12'h010, 2);
    n = 1 + $urandom_range(5);
    apb(1, 12'h004, n);
    rt.send_pattern(n - 1);
    repeat (3) @(posedge clk);
    chk("rx early", 0, irq);
    rt.send_pattern(1);
    repeat (3) @(posedge clk);
    chk("rx eot", 1, irq);
    apb(1, 12'h00C, 2);
    apb(1, 12'h004, 0);
    rt.send_pattern(6);
    repeat (3) @(posedge clk);
    chk("rx endless", 0, irq);
    apb(1, 12'h008, 1);
    for (n = 0; n < 2; n++) begin
      rt.send_msg(7'h7F - n, n);
      repeat (3) @(posedge clk);
      apb(0, 12'h004, 0);
      chk("rx ptr size", {n[0], 7'h7F - n[6:0]}, rd);
    end
    $display("rx test done");
    finish_test;
  end
endmodule
`default_nettype wire

// *** sim/hdlc_link_monitor.sv ***
// port-level assertions for the data-link buffer and count block
`timescale 1ns/1ns
`default_nettype none
module hdlc_link_monitor (
  input wire logic        REF_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        TX_UNIT_DONE_IN,
  input wire logic        TX_BUSY_OUT,
  input wire logic        TX_BUSY_BUF_OUT,
  input wire logic        TX_MSG_MODE_OUT,
  input wire logic        TX_IN_FCS_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence acc_s; PSEL_IN && PENABLE_IN; endsequence
  sequence start_s;
    PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 12'h000 && !TX_BUSY_OUT
      && PWDATA_IN[6:0] != 7'h00;
  endsequence
  sequence run_s; TX_BUSY_OUT [*2]; endsequence
  chk_ready_high: assert property (PREADY_OUT) else $error("ready low");
  chk_start_buf: assert property (start_s |-> ##2 TX_BUSY_OUT &&
    TX_BUSY_BUF_OUT == $past(PWDATA_IN[7], 2)) else $error("start wrong");
  chk_buf_hold: assert property (run_s |-> $stable(TX_BUSY_BUF_OUT))
    else $error("buffer moved");
  chk_end_on_unit: assert property ($fell(TX_BUSY_OUT) |-> $past(TX_UNIT_DONE_IN))
    else $error("end without unit");
  chk_unmapped_err: assert property (acc_s ##0 PADDR_IN > 12'h010 |-> PSLVERR_OUT)
    else $error("no slave error");
  chk_unmapped_zero: assert property (acc_s ##0 PADDR_IN > 12'h010 && !PWRITE_IN
    |-> PRDATA_OUT == 32'h0) else $error("unmapped data");
  chk_mode_follow: assert property (acc_s ##0 PWRITE_IN && PADDR_IN == 12'h008
    |=> TX_MSG_MODE_OUT == $past(PWDATA_IN[0])) else $error("mode wrong");
  chk_fcs_scope: assert property (TX_IN_FCS_OUT |-> TX_MSG_MODE_OUT)
    else $error("check octets in bit mode");
  chk_fcs_busy: assert property (TX_IN_FCS_OUT |-> TX_BUSY_OUT)
    else $error("check octets while idle");
  chk_fcs_after: assert property ($rose(TX_IN_FCS_OUT) |-> $past(TX_UNIT_DONE_IN))
    else $error("check octets early");
endmodule
bind hdlc_datalink_buffer_count hdlc_link_monitor mon (
  .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .TX_UNIT_DONE_IN(TX_UNIT_DONE_IN),
  .TX_BUSY_OUT(TX_BUSY_OUT), .TX_BUSY_BUF_OUT(TX_BUSY_BUF_OUT),
  .TX_MSG_MODE_OUT(TX_MSG_MODE_OUT), .TX_IN_FCS_OUT(TX_IN_FCS_OUT));
`default_nettype wire

// *** sim/hdlc_remote_term.sv ***
// remote terminal model: paces transmit units and sources receive events
`timescale 1ns/1ns
`default_nettype none
module hdlc_remote_term (
  input  wire logic       clk_in,
  input  wire logic       busy_in,
  output var  logic       unit_done_out,
  output var  logic       pattern_out,
  output var  logic       msg_done_out,
  output var  logic [6:0] msg_size_out,
  output var  logic       msg_buf_out
);
  initial {unit_done_out, pattern_out, msg_done_out, msg_size_out, msg_buf_out} = '0;
  // random pacing, never two in a row, so late pulses cannot leak past the end
  always @(posedge clk_in)
    unit_done_out <= busy_in && !unit_done_out && $urandom_range(1) == 0;
  task automatic send_pattern(int n);
    repeat (n) begin
      @(posedge clk_in) pattern_out <= 1'b1;
      @(posedge clk_in) pattern_out <= 1'b0;
    end
  endtask
  // size and buffer lines flip once the strobe drops
  task automatic send_msg(logic [6:0] s, logic b);
    @(posedge clk_in);
    msg_done_out <= 1'b1;
    msg_size_out <= s;
    msg_buf_out <= b;
    @(posedge clk_in);
    msg_done_out <= 1'b0;
    msg_size_out <= ~s;
    msg_buf_out <= ~b;
  endtask
endmodule
`default_nettype wire

// *** src/hdlc_datalink_buffer_count.v ***
// apb register file and glue for the first data-link buffer select and count block
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_link_regs.vh"
module hdlc_datalink_buffer_count #(
  parameter CW = 7
) (
  input  wire          REF_CLK_IN,
  input  wire          RST_N_IN,
  input  wire          PSEL_IN,
  input  wire          PENABLE_IN,
  input  wire          PWRITE_IN,
  input  wire [11:0]   PADDR_IN,
  input  wire [31:0]   PWDATA_IN,
  output reg  [31:0]   PRDATA_OUT,
  output wire          PREADY_OUT,
  output wire          PSLVERR_OUT,
  input  wire          TX_UNIT_DONE_IN,
  input  wire          RX_PATTERN_IN,
  input  wire          RX_MSG_DONE_IN,
  input  wire [CW-1:0] RX_MSG_SIZE_IN,
  input  wire          RX_MSG_BUF_IN,
  output wire          TX_BUSY_OUT,
  output wire          TX_BUSY_BUF_OUT,
  output wire          TX_MSG_MODE_OUT,
  output wire          TX_IN_FCS_OUT,
  output wire          IRQ_OUT
);
  reg  [CW-1:0] tx_length_repeat_count;
  reg  [CW-1:0] rx_length_repeat_count;
  reg           rx_newest_buffer_pointer;
  reg           signalling_type_select;
  reg           frame_check_append_enable;
  reg  [1:0]    irq_status;
  reg  [1:0]    irq_mask;
  reg  [1:0]    next_irq_status;
  reg           tx_start;
  reg           tx_start_buf;
  reg           tx_buffer_free_select;
  wire          tx_busy;
  wire          tx_busy_buf;
  wire          tx_in_fcs;
  wire          tx_end_of_transfer_irq;
  wire          rx_end_of_transfer_irq;
  wire          rx_store;
  wire [CW-1:0] rx_size;
  wire          rx_buf;
  wire          wr;
  wire          rd_ok;
  wire          mapped;

  assign wr          = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign PREADY_OUT  = 1'b1;
  assign mapped      = (PADDR_IN == `ADDR_TX_SEL_COUNT) || (PADDR_IN == `ADDR_RX_PTR_COUNT) ||
                       (PADDR_IN == `ADDR_LINK_CTRL) || (PADDR_IN == `ADDR_IRQ_STATUS) ||
                       (PADDR_IN == `ADDR_IRQ_MASK);
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign rd_ok       = 1'b1;

  // the free buffer is the one not held by a message in flight
  always @* begin
    if (tx_busy)
      tx_buffer_free_select = ~tx_busy_buf; // RULE3
    else
      tx_buffer_free_select = tx_start_buf; // RULE2
  end

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_length_repeat_count    <= {CW{1'b0}}; // RULE13
      rx_length_repeat_count    <= {CW{1'b0}};
      rx_newest_buffer_pointer  <= 1'b0;
      signalling_type_select    <= 1'b0;
      frame_check_append_enable <= 1'b0;
      irq_mask                  <= 2'h0;
      tx_start                  <= 1'b0;
      tx_start_buf              <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (wr && PADDR_IN == `ADDR_TX_SEL_COUNT) begin
        tx_length_repeat_count <= PWDATA_IN[CW-1:0]; // RULE6
        // selecting the busy buffer starts nothing, though the count field is still written and the message keeps running
        if (!(tx_busy && PWDATA_IN[`BIT_BUF_SEL] == tx_busy_buf)) begin // RULE3
          tx_start     <= 1'b1; // RULE1
          tx_start_buf <= PWDATA_IN[`BIT_BUF_SEL];
        end
      end
      if (wr && PADDR_IN == `ADDR_LINK_CTRL) begin
        signalling_type_select    <= PWDATA_IN[`BIT_MODE_SEL]; // RULE11
        frame_check_append_enable <= PWDATA_IN[`BIT_FCS_EN];   // RULE12
      end
      if (wr && PADDR_IN == `ADDR_IRQ_MASK)
        irq_mask <= PWDATA_IN[1:0];
      // hardware capture beats a software write in the same cycle
      if (rx_store) begin
        rx_length_repeat_count   <= rx_size; // RULE10
        rx_newest_buffer_pointer <= rx_buf;  // RULE7
      end else if (wr && PADDR_IN == `ADDR_RX_PTR_COUNT) begin
        rx_length_repeat_count   <= PWDATA_IN[CW-1:0]; // RULE8
        rx_newest_buffer_pointer <= PWDATA_IN[`BIT_BUF_SEL];
      end
    end
  end

  always @* begin
    next_irq_status = irq_status;
    if (wr && PADDR_IN == `ADDR_IRQ_STATUS)
      next_irq_status = irq_status & ~PWDATA_IN[1:0];
    next_irq_status[`BIT_IRQ_TX_EOT] = next_irq_status[`BIT_IRQ_TX_EOT] | tx_end_of_transfer_irq;
    next_irq_status[`BIT_IRQ_RX_EOT] = next_irq_status[`BIT_IRQ_RX_EOT] | rx_end_of_transfer_irq;
  end

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)
      irq_status <= 2'h0;
    else
      irq_status <= next_irq_status;
  end

  assign IRQ_OUT = |(irq_status & irq_mask);

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && rd_ok) begin
      case (PADDR_IN)
        `ADDR_TX_SEL_COUNT:
          PRDATA_OUT <= {24'h000000, tx_buffer_free_select, tx_length_repeat_count}; // RULE2
        `ADDR_RX_PTR_COUNT:
          PRDATA_OUT <= {24'h000000, rx_newest_buffer_pointer, rx_length_repeat_count};
        `ADDR_LINK_CTRL:
          PRDATA_OUT <= {30'h00000000, frame_check_append_enable, signalling_type_select};
        `ADDR_IRQ_STATUS:
          PRDATA_OUT <= {30'h00000000, irq_status};
        `ADDR_IRQ_MASK:
          PRDATA_OUT <= {30'h00000000, irq_mask};
        default:
          PRDATA_OUT <= 32'h00000000;
      endcase
    end
  end

  hdlc_tx_counter #(
    .CW(CW)
  ) u_tx (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (RST_N_IN),
    .start_in     (tx_start),
    .start_buf_in (tx_start_buf),
    .count_in     (tx_length_repeat_count),
    .msg_mode_in  (signalling_type_select),
    .fcs_en_in    (frame_check_append_enable),
    .unit_done_in (TX_UNIT_DONE_IN),
    .busy_out     (tx_busy),
    .busy_buf_out (tx_busy_buf),
    .in_fcs_out   (tx_in_fcs),
    .eot_out      (tx_end_of_transfer_irq)
  );

  hdlc_rx_counter #(
    .CW(CW)
  ) u_rx (
    .clk_in          (REF_CLK_IN),
    .rst_n_in        (RST_N_IN),
    .msg_mode_in     (signalling_type_select),
    .repeat_limit_in (rx_length_repeat_count),
    .pattern_in      (RX_PATTERN_IN),
    .msg_done_in     (RX_MSG_DONE_IN),
    .msg_size_in     (RX_MSG_SIZE_IN),
    .msg_buf_in      (RX_MSG_BUF_IN),
    .eot_out         (rx_end_of_transfer_irq),
    .store_out       (rx_store),
    .size_out        (rx_size),
    .buf_out         (rx_buf)
  );

  assign TX_BUSY_OUT     = tx_busy;
  assign TX_BUSY_BUF_OUT = tx_busy_buf;
  assign TX_MSG_MODE_OUT = signalling_type_select;
  assign TX_IN_FCS_OUT   = tx_in_fcs;
endmodule
`default_nettype wire

// *** src/hdlc_link_regs.vh ***
// register map, field layout and reset values of the data-link buffer and count block
// Behaviour
// RULE1 - a write of the select bit picks transmit buffer 0 or 1 as the source of the next message.
// RULE2 - a read of the select bit returns the next free transmit buffer, 0 at 0x0600 and 1 at 0x0700.
// RULE3 - while one buffer is still in use the select bit reads the other one, and software may not select the busy one.
// RULE4 - in bit pattern mode the transmit count sets the repetitions, after which the end-of-transfer event fires and sending stops.
// RULE5 - in bit pattern mode a transmit count of zero repeats the pattern without limit.
// RULE6 - in message mode the transmit count is the length in octets with header but without frame check octets.
// RULE7 - the receive pointer bit shows which receive buffer holds the newest message.
// RULE8 - in bit pattern mode the receive count sets how many repetitions raise the receive end-of-transfer event.
// RULE9 - in bit pattern mode a receive count of zero receives forever and raises no receive event.
// RULE10 - in message mode the receive count reports the stored message size including header and frame check octets.
// RULE11 - the signalling type bit selects bit pattern mode at 0 and message mode at 1.
// RULE12 - with frame check enabled in message mode the transmitter appends frame check octets.
// RULE13 - after reset both counts read zero, transmit buffer 0 is selected and receive buffer 0 indicated.
`ifndef HDLC_LINK_REGS_VH
`define HDLC_LINK_REGS_VH
`define ADDR_TX_SEL_COUNT   12'h000
`define ADDR_RX_PTR_COUNT   12'h004
`define ADDR_LINK_CTRL      12'h008
`define ADDR_IRQ_STATUS     12'h00C
`define ADDR_IRQ_MASK       12'h010
`define TX_BUF0_BASE        16'h0600
`define TX_BUF1_BASE        16'h0700
`define BIT_BUF_SEL         7
`define BIT_MODE_SEL        0
`define BIT_FCS_EN          1
`define BIT_IRQ_TX_EOT      0
`define BIT_IRQ_RX_EOT      1
`define FCS_OCTETS          8'h02
`define RST_TX_SEL_COUNT    8'h00
`define RST_RX_PTR_COUNT    8'h00
`define RST_LINK_CTRL       2'h0
`endif

// *** src/hdlc_rx_counter.v ***
// receive side: newest-buffer pointer, size capture and repeat counting
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_link_regs.vh"
module hdlc_rx_counter #(
  parameter CW = 7
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          msg_mode_in,
  input  wire [CW-1:0] repeat_limit_in,
  input  wire          pattern_in,
  input  wire          msg_done_in,
  input  wire [CW-1:0] msg_size_in,
  input  wire          msg_buf_in,
  output reg           eot_out,
  output reg           store_out,
  output reg  [CW-1:0] size_out,
  output reg           buf_out
);
  reg [CW-1:0] seen;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen      <= {CW{1'b0}};
      eot_out   <= 1'b0;
      store_out <= 1'b0;
      size_out  <= {CW{1'b0}};
      buf_out   <= 1'b0;
    end else begin
      eot_out   <= 1'b0;
      store_out <= 1'b0;
      if (msg_mode_in && msg_done_in) begin
        store_out <= 1'b1;
        size_out  <= msg_size_in; // RULE10
        buf_out   <= msg_buf_in;  // RULE7
        eot_out   <= 1'b1;
      end else if (!msg_mode_in && pattern_in && repeat_limit_in != {CW{1'b0}}) begin // RULE9
        if (seen + 1'b1 == repeat_limit_in) begin
          eot_out <= 1'b1; // RULE8
          seen    <= {CW{1'b0}};
        end else begin
          seen <= seen + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** src/hdlc_tx_counter.v ***
// transmit side: buffer ownership and length or repeat counting
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_link_regs.vh"
module hdlc_tx_counter #(
  parameter CW = 7
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          start_in,
  input  wire          start_buf_in,
  input  wire [CW-1:0] count_in,
  input  wire          msg_mode_in,
  input  wire          fcs_en_in,
  input  wire          unit_done_in,
  output reg           busy_out,
  output reg           busy_buf_out,
  output reg           in_fcs_out,
  output reg           eot_out
);
  reg [7:0] sent;
  reg [7:0] limit;

  always @* begin
    if (msg_mode_in && fcs_en_in)
      limit = {1'b0, count_in} + `FCS_OCTETS; // RULE6 RULE12
    else
      limit = {1'b0, count_in};
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out     <= 1'b0;
      busy_buf_out <= 1'b0;
      sent         <= 8'h00;
      eot_out      <= 1'b0;
      in_fcs_out   <= 1'b0;
    end else begin
      eot_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out     <= 1'b1;
        busy_buf_out <= start_buf_in; // RULE1
        sent         <= 8'h00;
        in_fcs_out   <= 1'b0;
      end else if (busy_out && unit_done_in) begin
        // zero count in pattern mode repeats until a nonzero count, message mode or reset
        if (!msg_mode_in && count_in == {CW{1'b0}}) begin
          sent <= 8'h00; // RULE5
        end else if (sent + 8'h01 >= limit) begin
          busy_out   <= 1'b0; // RULE4
          eot_out    <= 1'b1;
          sent       <= 8'h00;
          // leaving the check octets with the frame, not at the next start
          in_fcs_out <= 1'b0; // RULE12
        end else begin
          sent       <= sent + 8'h01;
          in_fcs_out <= msg_mode_in && fcs_en_in && (sent + 8'h01 >= {1'b0, count_in});
        end
      end
    end
  end
endmodule
`default_nettype wire
